// ### drbm_consts.svh
// Purpose: Offsets and fields of the ring host.
// Assumes: Included by bare name; holds definitions only.
// Notes: Register offsets and descriptor bits.
`ifndef DRBM_CONSTS_SVH
`define DRBM_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define DRBM_OFS_CTRL 8'h00
`define DRBM_OFS_RXRING 8'h04
`define DRBM_OFS_TXRING 8'h08
`define DRBM_OFS_RXBUF 8'h0C
`define DRBM_OFS_TXBUF 8'h10
`define DRBM_OFS_BUFLEN 8'h14
`define DRBM_OFS_STAT 8'h18
`define DRBM_OFS_FRAME 8'h1C
`define DRBM_OFS_UNMAPPED 8'hFF

// ****************************************
// Software register fields
// ****************************************
`define DRBM_CMD_GO 0
`define DRBM_CMD_INIT 1
`define DRBM_CMD_RECLAIM 2
`define DRBM_RXLEN_MIN 12'h040
`define DRBM_TXLEN_MIN 12'h064
`define DRBM_BUFLEN_RST 12'h040

// ****************************************
// Descriptor word 1 and word 2 fields
// ****************************************
`define DRBM_OWN_BIT 15
`define DRBM_FAULT_BIT 14
`define DRBM_LAST_SEG_BIT 8
`define DRBM_W2_ONES 4'hF

// ****************************************
// Device primary control word access
// ****************************************
`define DRBM_CTRL_WORD_ADDR 24'h000000
`define DRBM_GO_BIT_VALUE 16'h0002

`endif

// ### drbm_pkg.sv
// Purpose: Types shared by the ring host modules.
// Assumes: Used only through drbm_pkg::name.
// Notes: Binary state codes are written out.
package drbm_pkg;

    // Controller states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_INIT_RX = 3'h1,
        ST_INIT_TX = 3'h2,
        ST_GO = 3'h3,
        ST_RD1 = 3'h4,
        ST_RD3 = 3'h5,
        ST_ARM = 3'h6
    } drbm_state_type;

endpackage

// ### drbm_reg_if.sv
// Purpose: Register access path between the bus slave and the core.
// Assumes: One clock; write strobe is a one-cycle pulse.
// Notes: Read data is combinational from core flops.
`timescale 1ns/100ps

interface drbm_reg_if;
    logic wrEn; // One-cycle write strobe.
    logic [7:0] wrAddr; // Byte offset of the write.
    logic [31:0] wrData; // Write data.
    logic [7:0] rdAddr; // Byte offset being read.
    logic [31:0] rdData; // Read data for rdAddr.

    modport bus (output wrEn, output wrAddr, output wrData,
                 output rdAddr, input rdData);
    modport core (input wrEn, input wrAddr, input wrData,
                  input rdAddr, output rdData);
endinterface

// ### drbm_ring_ptr.sv
// Purpose: Modulo entry counter giving the entry address.
// Assumes: Base is quadword aligned by the caller.
// Notes: Ring holds two to the power of the size code entries.
`timescale 1ns/100ps
`include "drbm_consts.svh"

module drbm_ring_ptr (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic advance,
    input wire logic [23:0] base,
    input wire logic [2:0] sizeCode,
    output logic [23:0] ptr,
    output logic [6:0] idx,
    output logic atEnd
);
    logic [6:0] idx_r; // Current entry number.
    logic [6:0] idx_nxt; // Next entry number.
    logic [6:0] lastIdx; // Number of the final entry.

    // ****************************************
    // Next entry and wrap
    // ****************************************
    always_comb begin
        lastIdx = 7'(({1'b0, 7'h7F}) >> (3'h7 - sizeCode));
        idx_nxt = idx_r;
        if (load) begin
            idx_nxt = 7'h00;
        end else if (advance) begin
            if (idx_r == lastIdx) begin
                idx_nxt = 7'h00; // Back to the ring base.
            end else begin
                idx_nxt = idx_r + 7'h01;
            end
        end
    end

    // Register the entry number.
    always_ff @(posedge clk) begin
        if (rst) begin
            idx_r <= 7'h00;
        end else begin
            idx_r <= idx_nxt;
        end
    end

    // Base plus eight bytes per entry.
    assign ptr = base + 24'({idx_r, 3'h0});
    assign idx = idx_r;
    assign atEnd = (idx_r == lastIdx);
endmodule

// ### drbm_ahb_slave.sv
// Purpose: AHB-Lite slave in front of the ring host registers.
// Assumes: Single word transfers; no wait states.
// Notes: Response is always OKAY; unmapped offsets read zero.
`timescale 1ns/100ps

module drbm_ahb_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    drbm_reg_if.bus regs
);
    logic wrPend_r; // A write data phase is due.
    logic wrPend_nxt;
    logic [7:0] wrAddr_r; // Offset held for the write data phase.
    logic [7:0] wrAddr_nxt;
    logic [31:0] hrdata_r; // Read data for the data phase.
    logic [31:0] hrdata_nxt;
    logic addrPhase; // Valid transfer in its address phase.
    logic [7:0] ofs; // Decoded offset or the unmapped marker.

    // ****************************************
    // Address phase decode
    // ****************************************
    always_comb begin
        addrPhase = hsel & htrans[1] & hready;
        if (haddr[31:5] == 27'h0000000 && hsize == 3'h2) begin
            ofs = {3'h0, haddr[4:2], 2'h0};
        end else begin
            ofs = `DRBM_OFS_UNMAPPED;
        end
        wrPend_nxt = addrPhase & hwrite;
        wrAddr_nxt = addrPhase ? ofs : wrAddr_r;
        hrdata_nxt = (addrPhase & ~hwrite) ? regs.rdData : 32'h00000000;
    end

    // Register the data phase state.
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end else begin
            wrPend_r <= wrPend_nxt;
            wrAddr_r <= wrAddr_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    assign regs.rdAddr = ofs;
    assign regs.wrEn = wrPend_r;
    assign regs.wrAddr = wrAddr_r;
    assign regs.wrData = hwdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
endmodule

// ### drbm_host_ctrl.sv
// Purpose: Host side of a descriptor ring pair shared with a network device.
// Assumes: Memory and device control word share one 16-bit port.
// Notes: Port handshake is four-phase; ack and read data are synchronised.
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "drbm_consts.svh"

// How it works
// - Receive ring base has three low zeros.
// - Transmit ring base has three low zeros.
// - Each entry is four 16-bit words.
// - Receive buffers are at least 64 bytes.
// - Only hand entries over, never touch after.
// - Chained transmit buffers are at least 100 bytes.
// - Word 1 bit 15 is ownership.
// - Device never alters buffer address.
// - Word 2 holds ones and negative length.
// - Words sit at byte offsets 0,2,4,6.
module drbm_host_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic memReq,
    output logic memWr,
    output logic memSel,
    output logic [23:0] memAddr,
    output logic [15:0] memWdata,
    input wire logic memAck,
    input wire logic [15:0] memRdata
);
    // ****************************************
    // Declarations
    // ****************************************
    drbm_reg_if regs (); // Register path from the bus slave.
    drbm_pkg::drbm_state_type state_r, state_nxt; // Controller state.
    logic [1:0] step_r, step_nxt; // Word step inside an entry.
    logic [31:0] rxRing_r, rxRing_nxt; // Rx ring setup.
    logic [31:0] txRing_r, txRing_nxt; // Tx ring setup.
    logic [23:0] rxBuf_r, rxBuf_nxt; // First rx buffer.
    logic [23:0] txBuf_r, txBuf_nxt; // First tx buffer.
    logic [11:0] rxLen_r, rxLen_nxt; // Rx buffer bytes.
    logic [11:0] txLen_r, txLen_nxt; // Tx buffer bytes.
    logic [15:0] lastStat_r, lastStat_nxt; // Word 1 of the last frame.
    logic [11:0] frameLen_r, frameLen_nxt; // Last good frame length.
    logic [7:0] frames_r, frames_nxt; // Reclaimed buffer count.
    logic empty_r, empty_nxt; // Reclaim found no released entry.
    logic req_r, req_nxt; // Port request level.
    logic waitLow_r, waitLow_nxt; // Waiting for ack to fall.
    logic [15:0] rdLat_r, rdLat_nxt; // Read data caught at ack.
    logic [23:0] addr_r, addr_nxt; // Port address.
    logic [15:0] wdat_r, wdat_nxt; // Port write data.
    logic wr_r, wr_nxt; // Port direction.
    logic sel_r, sel_nxt; // Port targets the device control word.
    logic ack1_r, ack2_r; // Ack synchroniser.
    logic [15:0] rd1_r, rd2_r; // Read data synchroniser.
    logic accDone; // Current port access finished this cycle.
    logic [23:0] rxPtr, txPtr; // Current entry addresses.
    logic [6:0] rxIdx, txIdx; // Current entry numbers.
    logic rxEnd, txEnd; // Pointer is on the final entry.
    logic rxLoad, txLoad, rxAdv, txAdv; // Pointer controls.
    logic [1:0] word; // Descriptor word for this step.
    logic [15:0] accData; // Data wanted for this step.
    logic [23:0] accAddr; // Address wanted for this step.
    logic isTx; // Step works on the transmit ring.
    logic [23:0] bufAddr; // Buffer address of the current entry.

    // Entry buffer: base plus index times length.
    function automatic logic [23:0] entryBuf(input logic [23:0] base,
                                             input logic [6:0] idx,
                                             input logic [11:0] len);
        entryBuf = base + 24'(idx * len);
    endfunction

    // Clamp a length up to its minimum.
    function automatic logic [11:0] atLeast(input logic [11:0] val,
                                            input logic [11:0] low);
        atLeast = (val < low) ? low : val;
    endfunction

    // ****************************************
    // Submodules
    // ****************************************
    drbm_ahb_slave slave (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .regs(regs.bus));

    drbm_ring_ptr rxRingPtr (.clk(clk), .rst(rst), .load(rxLoad),
        .advance(rxAdv), .base({rxRing_r[23:3], 3'h0}),
        .sizeCode(rxRing_r[30:28]), .ptr(rxPtr), .idx(rxIdx),
        .atEnd(rxEnd));

    drbm_ring_ptr txRingPtr (.clk(clk), .rst(rst), .load(txLoad),
        .advance(txAdv), .base({txRing_r[23:3], 3'h0}),
        .sizeCode(txRing_r[30:28]), .ptr(txPtr), .idx(txIdx),
        .atEnd(txEnd));

    // ****************************************
    // Synchronise the port answer
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            ack1_r <= 1'b0;
            ack2_r <= 1'b0;
            rd1_r <= 16'h0000;
            rd2_r <= 16'h0000;
        end else begin
            ack1_r <= memAck;
            ack2_r <= ack1_r;
            rd1_r <= memRdata;
            rd2_r <= rd1_r;
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    always_comb begin
        case (regs.rdAddr)
            `DRBM_OFS_RXRING: regs.rdData = rxRing_r;
            `DRBM_OFS_TXRING: regs.rdData = txRing_r;
            `DRBM_OFS_RXBUF: regs.rdData = {8'h00, rxBuf_r};
            `DRBM_OFS_TXBUF: regs.rdData = {8'h00, txBuf_r};
            `DRBM_OFS_BUFLEN: regs.rdData = {4'h0, txLen_r, 4'h0, rxLen_r};
            `DRBM_OFS_STAT: regs.rdData = {lastStat_r, 14'h0000, empty_r,
                                           (state_r != drbm_pkg::ST_IDLE)};
            `DRBM_OFS_FRAME: regs.rdData = {8'h00, frames_r, 4'h0, frameLen_r};
            default: regs.rdData = 32'h00000000;
        endcase
    end

    // ****************************************
    // Step data: word order and contents
    // ****************************************
    always_comb begin
        isTx = (state_r == drbm_pkg::ST_INIT_TX);
        // Ownership word last: entry complete at handover.
        case (step_r)
            2'h0: word = 2'h0;
            2'h1: word = 2'h2;
            2'h2: word = 2'h3;
            default: word = 2'h1;
        endcase
        if (state_r == drbm_pkg::ST_RD1) begin
            word = 2'h1;
        end else if (state_r == drbm_pkg::ST_RD3) begin
            word = 2'h3;
        end
        bufAddr = isTx ? entryBuf(txBuf_r, txIdx, txLen_r)
                       : entryBuf(rxBuf_r, rxIdx, rxLen_r);
        accAddr = (isTx ? txPtr : rxPtr) + 24'({word, 1'b0});
        case (word)
            2'h0: accData = bufAddr[15:0];
            2'h1: accData = {~isTx, 7'h00, bufAddr[23:16]};
            // Ones on top, length as a negative count below.
            2'h2: accData = {`DRBM_W2_ONES,
                             12'(-(isTx ? txLen_r : rxLen_r))};
            default: accData = 16'h0000; // Clears the frame length.
        endcase
        if (state_r == drbm_pkg::ST_GO) begin
            accAddr = `DRBM_CTRL_WORD_ADDR;
            accData = `DRBM_GO_BIT_VALUE;
        end
    end

    // ****************************************
    // Port handshake and controller
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        step_nxt = step_r;
        rxRing_nxt = rxRing_r;
        txRing_nxt = txRing_r;
        rxBuf_nxt = rxBuf_r;
        txBuf_nxt = txBuf_r;
        rxLen_nxt = rxLen_r;
        txLen_nxt = txLen_r;
        lastStat_nxt = lastStat_r;
        frameLen_nxt = frameLen_r;
        frames_nxt = frames_r;
        empty_nxt = empty_r;
        req_nxt = req_r;
        waitLow_nxt = waitLow_r;
        rdLat_nxt = rdLat_r;
        addr_nxt = addr_r;
        wdat_nxt = wdat_r;
        wr_nxt = wr_r;
        sel_nxt = sel_r;
        rxLoad = 1'b0;
        txLoad = 1'b0;
        rxAdv = 1'b0;
        txAdv = 1'b0;
        accDone = 1'b0;
        // Setup writes are taken only while idle.
        if (regs.wrEn && state_r == drbm_pkg::ST_IDLE) begin
            case (regs.wrAddr)
                `DRBM_OFS_RXRING: rxRing_nxt = {1'b0, regs.wrData[30:28],
                                               4'h0, regs.wrData[23:3], 3'h0};
                `DRBM_OFS_TXRING: txRing_nxt = {1'b0, regs.wrData[30:28],
                                               4'h0, regs.wrData[23:3], 3'h0};
                `DRBM_OFS_RXBUF: rxBuf_nxt = regs.wrData[23:0];
                `DRBM_OFS_TXBUF: txBuf_nxt = regs.wrData[23:0];
                `DRBM_OFS_BUFLEN: begin
                    rxLen_nxt = atLeast(regs.wrData[11:0],
                                        `DRBM_RXLEN_MIN);
                    txLen_nxt = atLeast(regs.wrData[27:16],
                                        `DRBM_TXLEN_MIN);
                end
                `DRBM_OFS_CTRL: begin
                    if (regs.wrData[`DRBM_CMD_INIT]) begin
                        state_nxt = drbm_pkg::ST_INIT_RX;
                        rxLoad = 1'b1;
                        txLoad = 1'b1;
                    end else if (regs.wrData[`DRBM_CMD_GO]) begin
                        state_nxt = drbm_pkg::ST_GO;
                    end else if (regs.wrData[`DRBM_CMD_RECLAIM]) begin
                        state_nxt = drbm_pkg::ST_RD1;
                    end
                    step_nxt = 2'h0;
                    empty_nxt = 1'b0;
                end
                default: begin
                    // Other offsets are read only or unmapped.
                end
            endcase
        end
        // Four-phase access: raise, wait ack high, drop, wait ack low.
        if (state_r != drbm_pkg::ST_IDLE) begin
            if (!req_r && !waitLow_r) begin
                req_nxt = 1'b1;
                addr_nxt = accAddr;
                wdat_nxt = accData;
                sel_nxt = (state_r == drbm_pkg::ST_GO);
                wr_nxt = (state_r != drbm_pkg::ST_RD1) &&
                         (state_r != drbm_pkg::ST_RD3);
            end else if (req_r && ack2_r) begin
                req_nxt = 1'b0;
                waitLow_nxt = 1'b1;
                rdLat_nxt = rd2_r;
            end else if (waitLow_r && !ack2_r) begin
                waitLow_nxt = 1'b0;
                accDone = 1'b1;
            end
        end
        if (accDone) begin
            step_nxt = step_r + 2'h1;
            case (state_r)
                drbm_pkg::ST_INIT_RX: begin
                    if (step_r == 2'h3) begin
                        rxAdv = 1'b1;
                        if (rxEnd) begin
                            state_nxt = drbm_pkg::ST_INIT_TX;
                        end
                    end
                end
                drbm_pkg::ST_INIT_TX: begin
                    if (step_r == 2'h3) begin
                        txAdv = 1'b1;
                        if (txEnd) begin
                            state_nxt = drbm_pkg::ST_IDLE;
                        end
                    end
                end
                drbm_pkg::ST_RD1: begin
                    step_nxt = 2'h0;
                    if (rdLat_r[`DRBM_OWN_BIT]) begin
                        // Device owns it: leave it.
                        empty_nxt = 1'b1;
                        state_nxt = drbm_pkg::ST_IDLE;
                    end else if (rdLat_r[`DRBM_LAST_SEG_BIT]) begin
                        lastStat_nxt = rdLat_r;
                        state_nxt = drbm_pkg::ST_RD3;
                    end else begin
                        lastStat_nxt = rdLat_r;
                        state_nxt = drbm_pkg::ST_ARM;
                    end
                end
                drbm_pkg::ST_RD3: begin
                    step_nxt = 2'h0;
                    if (!lastStat_r[`DRBM_FAULT_BIT]) begin
                        frameLen_nxt = rdLat_r[11:0];
                    end
                    state_nxt = drbm_pkg::ST_ARM;
                end
                drbm_pkg::ST_ARM: begin
                    // Rewrite clears flags, hands entry back.
                    if (step_r == 2'h3) begin
                        rxAdv = 1'b1;
                        frames_nxt = frames_r + 8'h01;
                        state_nxt = drbm_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_nxt = drbm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Register all controller state.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= drbm_pkg::ST_IDLE;
            step_r <= 2'h0;
            rxRing_r <= 32'h00000000;
            txRing_r <= 32'h00000000;
            rxBuf_r <= 24'h000000;
            txBuf_r <= 24'h000000;
            rxLen_r <= `DRBM_BUFLEN_RST;
            txLen_r <= `DRBM_TXLEN_MIN;
            lastStat_r <= 16'h0000;
            frameLen_r <= 12'h000;
            frames_r <= 8'h00;
            empty_r <= 1'b0;
            req_r <= 1'b0;
            waitLow_r <= 1'b0;
            rdLat_r <= 16'h0000;
            addr_r <= 24'h000000;
            wdat_r <= 16'h0000;
            wr_r <= 1'b0;
            sel_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            step_r <= step_nxt;
            rxRing_r <= rxRing_nxt;
            txRing_r <= txRing_nxt;
            rxBuf_r <= rxBuf_nxt;
            txBuf_r <= txBuf_nxt;
            rxLen_r <= rxLen_nxt;
            txLen_r <= txLen_nxt;
            lastStat_r <= lastStat_nxt;
            frameLen_r <= frameLen_nxt;
            frames_r <= frames_nxt;
            empty_r <= empty_nxt;
            req_r <= req_nxt;
            waitLow_r <= waitLow_nxt;
            rdLat_r <= rdLat_nxt;
            addr_r <= addr_nxt;
            wdat_r <= wdat_nxt;
            wr_r <= wr_nxt;
            sel_r <= sel_nxt;
        end
    end

    assign memReq = req_r;
    assign memWr = wr_r;
    assign memSel = sel_r;
    assign memAddr = addr_r;
    assign memWdata = wdat_r;
endmodule

// ### drbm_host_ctrl_sva.sv
// Purpose: Port checks for the ring host controller.
// Assumes: One clock; reset synchronous and active high.
// Notes: Bound to every drbm_host_ctrl instance.
`timescale 1ns/100ps
module drbm_host_ctrl_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic memReq,
    input wire logic memWr,
    input wire logic memSel,
    input wire logic [23:0] memAddr,
    input wire logic [15:0] memWdata,
    input wire logic memAck
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Writes of descriptor words 2 and 3.
    logic memW2;
    logic memW3;
    assign memW2 = memReq && memWr && !memSel && memAddr[2:0] == 3'h4;
    assign memW3 = memReq && memWr && !memSel && memAddr[2:0] == 3'h6;
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not OKAY");
    a_rdata_idle: assert property (!$past(hsel && htrans[1] && !hwrite)
        |-> hrdata == 32'h0) else $error("stray read data");
    a_req_hold: assert property (memReq && !memAck |=> memReq)
        else $error("request dropped early");
    a_req_stable: assert property (memReq && $past(memReq) |->
        $stable({memAddr, memWr, memSel, memWdata}))
        else $error("request fields moved");
    a_req_release: assert property ($rose(memAck) |-> ##[1:4] !memReq)
        else $error("request held too long");
    a_word_align: assert property (memReq && !memSel |->
        !memAddr[0]) else $error("odd word address");
    a_len_word: assert property (memW2 |-> memWdata[15:12] == 4'hF &&
        memWdata[11:0] <= 12'hFC0 && memWdata[11:0] != 12'h0)
        else $error("bad length word");
    a_count_clear: assert property (memW3 |-> memWdata == 16'h0)
        else $error("word 3 not cleared");
    a_go_word: assert property (memReq && memSel |-> memWr &&
        memAddr == 24'h0 && memWdata == 16'h0002)
        else $error("bad go access");
    c_go: cover property ($rose(memReq) && memSel);
    c_len: cover property (memW2);
    c_read: cover property ($rose(memReq) && !memWr);
endmodule
bind drbm_host_ctrl drbm_host_ctrl_sva u_sva (.clk(clk), .rst(rst),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .memReq(memReq), .memWr(memWr),
    .memSel(memSel), .memAddr(memAddr), .memWdata(memWdata),
    .memAck(memAck));

// ### drbm_dev_model.sv
// Purpose: Shared memory plus network device behind the memory port.
// Assumes: Four-phase port; ack delay set by dly.
// Notes: Go makes the device fill receive entry 0.
`timescale 1ns/100ps
module drbm_dev_model #(parameter logic [7:0] RX_IDX = 8'h20) (
    input wire logic clk,
    input wire logic rst,
    input wire logic memReq,
    input wire logic memWr,
    input wire logic memSel,
    input wire logic [23:0] memAddr,
    input wire logic [15:0] memWdata,
    input wire logic [2:0] dly,
    output logic memAck,
    output logic [15:0] memRdata
);
    logic [15:0] mem [0:255]; // Word-addressed shared memory.
    logic [2:0] cnt; // Wait cycles of the request.
    // Ack after dly cycles; data churns without ack.
    always @(posedge clk) begin
        if (rst) begin
            memAck <= 1'b0;
            cnt <= 3'h0;
            memRdata <= 16'h5A5A;
        end else begin
            cnt <= (memReq && !memAck) ? cnt + 3'h1 : 3'h0;
            memAck <= memReq && (memAck || cnt >= dly);
            if (!memAck)
                memRdata <= ~memRdata;
            if (memReq && !memAck && cnt >= dly) begin
                if (!memWr)
                    memRdata <= mem[memAddr[8:1]];
                else if (!memSel)
                    mem[memAddr[8:1]] <= memWdata;
                else if (memWdata[1]) begin
                    // Release one whole frame, keeping the pointer byte.
                    mem[RX_IDX + 8'h1][15:8] <= 8'h03;
                    mem[RX_IDX + 8'h3] <= 16'h002A;
                end
            end
        end
    end
endmodule

// ### descriptor_ring_buffer_mgmt_tb.sv
// Purpose: Self-checking bench for the ring host controller.
// Assumes: Rings at 0x40 and 0x80, buffers at 0x1000 and 0x2000.
// Notes: Stops on a cycle ceiling.
`timescale 1ns/100ps
module descriptor_ring_buffer_mgmt_tb;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, dly = 3'h0;
    logic hreadyout, hresp, memReq, memWr, memSel, memAck;
    logic [23:0] memAddr;
    logic [15:0] memWdata, memRdata;
    int nErrors = 0, numChecks = 0, cyc = 0;
    // Init image: word index, value.
    logic [23:0] tbl [10] = '{24'h201000, 24'h218000, 24'h22FFC0,
        24'h230000, 24'h241040, 24'h258000, 24'h26FFC0, 24'h270000,
        24'h402000, 24'h42FF9C};
    always #20 clk = ~clk;
    drbm_host_ctrl u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .memReq(memReq), .memWr(memWr), .memSel(memSel),
        .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
        .memRdata(memRdata));
    drbm_dev_model u_dev (.clk(clk), .rst(rst), .memReq(memReq),
        .memWr(memWr), .memSel(memSel), .memAddr(memAddr),
        .memWdata(memWdata), .dly(dly), .memAck(memAck),
        .memRdata(memRdata));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One AHB-Lite transfer; rd gets read data.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    // Polls busy until done.
    task automatic idle();
        repeat (3) @(posedge clk);
        rd = 32'h1;
        for (int i = 0; i < 300 && rd[0] !== 1'b0; i++)
            bus(1'b0, 8'h18, 32'h0);
        chk({31'h0, rd[0]}, 32'h0);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            nErrors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b1, 8'h04, 32'h10000040);
        bus(1'b1, 8'h08, 32'h00000080);
        bus(1'b1, 8'h0C, 32'h00001000);
        bus(1'b1, 8'h10, 32'h00002000);
        bus(1'b1, 8'h14, 32'h00000010);
        bus(1'b1, 8'h00, 32'h00000002);
        idle();
        for (int i = 0; i < 10; i++)
            chk(u_dev.mem[tbl[i][23:16]], tbl[i][15:0]);
        $display("test init done");
        dly <= 3'h5;
        bus(1'b1, 8'h00, 32'h00000001);
        idle();
        bus(1'b1, 8'h00, 32'h00000004);
        idle();
        bus(1'b0, 8'h18, 32'h0);
        chk(rd & 32'hFFFF0000, 32'h03000000);
        chk(u_dev.mem[8'h21], 32'h8000);
        bus(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'h0001002A);
        $display("test reclaim done");
        bus(1'b1, 8'h00, 32'h00000004);
        idle();
        bus(1'b0, 8'h18, 32'h0);
        chk({31'h0, rd[1]}, 32'h1);
        bus(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        $display("test empty ring done");
        report_and_stop();
    end
endmodule
